// *** core/hbm_core.sv ***
// H-bridge motor control and fault logic: direction decode, regulated
// PWM with soft start, current limit, protection and alarm output.
// Assumes analog comparators and ADC codes arrive synchronous to sys_clk.
`default_nettype none
module hbm_core (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       dir_ctrl_a,
  input  wire logic                       dir_ctrl_b,
  input  wire logic [hbm_pkg::ADC_W-1:0]  speed_setpoint_in,
  input  wire logic [hbm_pkg::ADC_W-1:0]  out_diff_in,
  input  wire logic [hbm_pkg::ADC_W-1:0]  supply_in,
  input  wire logic                       sense_resistor_in,
  input  wire logic [1:0]                 hs_overcurrent_in,
  input  wire logic [1:0]                 ls_overcurrent_in,
  input  wire logic                       overtemp_in,
  input  wire logic                       low_supply_in,
  input  wire logic [1:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic [7:0]                      reg_rdata,
  output logic                            irq,
  output logic [1:0]                      hs_gate,
  output logic [1:0]                      ls_gate,
  output logic                            sleep_out,
  output logic                            alarm_out_n
);
  // ****************************************************************
  // Reset and mode decode
  // ****************************************************************
  logic      lrst;
  logic      coast;
  logic      drive;
  logic      brake;
  logic      prev_drive_q;
  logic      prev_drive_d;
  logic      start_drive;
  hbm_pkg::hbm_mode_t mode;

  // Low supply resets the control logic like a power-on; status, mask, read data and alarm registers reset on rst only
  assign lrst = rst | low_supply_in;
  assign mode = hbm_pkg::hbm_mode_t'({dir_ctrl_a, dir_ctrl_b});
  assign coast = (mode == hbm_pkg::HBM_COAST);
  assign brake = (mode == hbm_pkg::HBM_BRAKE);
  assign drive = (mode == hbm_pkg::HBM_FORWARD) ||
                 (mode == hbm_pkg::HBM_REVERSE);
  assign prev_drive_d = drive;
  // Soft start triggers when driving follows coast, brake or reset, not on a direct reversal
  assign start_drive = drive & ~prev_drive_q;

  // ****************************************************************
  // Persistence timers
  // ****************************************************************
  logic ilim_active;
  logic ilim_long;
  logic ocp_raw;
  logic ocp_hit;

  // Short filter rejects sense spikes at switching edges
  hbm_timer #(.LIMIT(hbm_pkg::ILIM_FILT_CYC)) u_ilim_filt (
    .sys_clk (sys_clk),
    .rst     (lrst),
    .cond    (sense_resistor_in & drive),
    .expired (ilim_active)
  );

  // Long timer only runs while limiting is actually in force
  hbm_timer #(.LIMIT(hbm_pkg::ILIM_FAULT_CYC)) u_ilim_long (
    .sys_clk (sys_clk),
    .rst     (lrst),
    .cond    (ilim_active),
    .expired (ilim_long)
  );

  // Per-transistor flags, separate from the current-limit path
  assign ocp_raw = |{hs_overcurrent_in, ls_overcurrent_in};
  hbm_timer #(.LIMIT(hbm_pkg::OCP_DEGLITCH_CYC)) u_ocp (
    .sys_clk (sys_clk),
    .rst     (lrst),
    .cond    (ocp_raw),
    .expired (ocp_hit)
  );

  // ****************************************************************
  // Fault latches
  // ****************************************************************
  logic ilim_alarm_q;
  logic ilim_alarm_d;
  logic ocp_latch_q;
  logic ocp_latch_d;
  logic bridge_off;

  always_comb begin
    ilim_alarm_d = ilim_alarm_q;
    if (ilim_long) begin
      ilim_alarm_d = 1'b1;
    end else if (coast) begin
      ilim_alarm_d = 1'b0;
    end
    // Only rst or a low-supply event releases this latch
    ocp_latch_d = ocp_latch_q | ocp_hit;
  end

  always_ff @(posedge sys_clk) begin
    if (lrst) begin
      ilim_alarm_q <= 1'b0;
      ocp_latch_q  <= 1'b0;
      prev_drive_q <= 1'b0;
    end else begin
      ilim_alarm_q <= ilim_alarm_d;
      ocp_latch_q  <= ocp_latch_d;
      prev_drive_q <= prev_drive_d;
    end
  end

  assign bridge_off = ocp_latch_q | overtemp_in | low_supply_in;

  // ****************************************************************
  // Duty regulation
  // ****************************************************************
  logic [hbm_pkg::DUTY_W-1:0] duty_q;
  logic [hbm_pkg::DUTY_W-1:0] duty_d;
  logic [hbm_pkg::DUTY_W-1:0] ceil_q;
  logic [hbm_pkg::DUTY_W-1:0] ceil_d;
  logic [15:0]                rstep_q;
  logic [15:0]                rstep_d;
  logic [hbm_pkg::ADC_W+3:0]  avg_q;
  logic [hbm_pkg::ADC_W+3:0]  avg_d;
  logic [hbm_pkg::ADC_W-1:0]  avg_div;
  logic                       bypass;
  logic                       pwm_on;
  logic                       pwm_start;

  // Setpoint is a quarter of target voltage, so compare against four times
  assign bypass = ({2'b00, speed_setpoint_in} << hbm_pkg::VDIV_SHIFT) >
                  {2'b00, supply_in};
  // Averaged differential voltage, scaled down by four
  assign avg_div = avg_q[hbm_pkg::ADC_W+3:4] >> hbm_pkg::VDIV_SHIFT;

  always_comb begin
    // First-order averaging filter, weight one sixteenth
    avg_d = avg_q - (avg_q >> 4) + {4'h0, out_diff_in};
    rstep_d = rstep_q;
    ceil_d  = ceil_q;
    duty_d  = duty_q;
    if (start_drive || !drive) begin
      ceil_d  = hbm_pkg::DUTY_ZERO;
      duty_d  = hbm_pkg::DUTY_ZERO;
      rstep_d = 16'h0000;
    end else begin
      // Ramp ceiling climbs one code per step, full in about 12 ms
      if (rstep_q >= 16'(hbm_pkg::RAMP_STEP_CYC - 1)) begin
        rstep_d = 16'h0000;
        if (ceil_q != hbm_pkg::DUTY_FULL) begin
          ceil_d = ceil_q + 8'h01;
        end
      end else begin
        rstep_d = rstep_q + 16'h0001;
      end
      // Adjust once per PWM period to keep the loop slow and stable
      if (pwm_start) begin
        if (ilim_active) begin
          if (duty_q != hbm_pkg::DUTY_ZERO) begin
            duty_d = duty_q - 8'h01;
          end
        end else if (bypass) begin
          duty_d = hbm_pkg::DUTY_FULL;
        end else if (avg_div < speed_setpoint_in) begin
          if (duty_q != hbm_pkg::DUTY_FULL) begin
            duty_d = duty_q + 8'h01;
          end
        end else if (avg_div > speed_setpoint_in) begin
          if (duty_q != hbm_pkg::DUTY_ZERO) begin
            duty_d = duty_q - 8'h01;
          end
        end
      end
      // Soft-start ceiling bounds every path, full duty included
      if (duty_d > ceil_d) begin
        duty_d = ceil_d;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (lrst) begin
      duty_q  <= hbm_pkg::DUTY_ZERO;
      ceil_q  <= hbm_pkg::DUTY_ZERO;
      rstep_q <= 16'h0000;
      avg_q   <= '0;
    end else begin
      duty_q  <= duty_d;
      ceil_q  <= ceil_d;
      rstep_q <= rstep_d;
      avg_q   <= avg_d;
    end
  end

  hbm_pwm u_pwm (
    .sys_clk      (sys_clk),
    .rst          (lrst),
    .duty         (duty_q),
    .on_time      (pwm_on),
    .period_start (pwm_start)
  );

  // ****************************************************************
  // Gate drive, index 0 is output one, index 1 output two
  // ****************************************************************
  logic [1:0] hs_d;
  logic [1:0] ls_d;
  logic [1:0] hs_q;
  logic [1:0] ls_q;
  logic       sleep_q;

  always_comb begin
    hs_d = 2'b00;
    ls_d = 2'b00;
    if (bridge_off || coast) begin
      hs_d = 2'b00;
      ls_d = 2'b00;
    end else if (brake) begin
      hs_d = 2'b11;
    end else if (!pwm_on) begin
      // Off-time recirculates through both high sides
      hs_d = 2'b11;
    end else if (mode == hbm_pkg::HBM_FORWARD) begin
      hs_d = 2'b01;
      ls_d = 2'b10;
    end else begin
      hs_d = 2'b10;
      ls_d = 2'b01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (lrst) begin
      hs_q    <= 2'b00;
      ls_q    <= 2'b00;
      sleep_q <= 1'b1;
    end else begin
      hs_q    <= hs_d;
      ls_q    <= ls_d;
      sleep_q <= coast;
    end
  end

  assign hs_gate   = hs_q;
  assign ls_gate   = ls_q;
  assign sleep_out = sleep_q;

  // ****************************************************************
  // Status, mask and alarm
  // ****************************************************************
  logic [3:0] live;
  logic [3:0] stat_q;
  logic [3:0] stat_d;
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       alarm_q;

  assign live = {low_supply_in, overtemp_in, ocp_latch_q, ilim_alarm_q};

  always_comb begin
    stat_d  = stat_q;
    mask_d  = mask_q;
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        hbm_pkg::ADDR_STATUS: rdata_d = {4'h0, stat_q};
        hbm_pkg::ADDR_MASK:   rdata_d = {4'h0, mask_q};
        hbm_pkg::ADDR_LIVE:   rdata_d = {4'h0, live};
        hbm_pkg::ADDR_DUTY:   rdata_d = duty_q;
      endcase
      if (reg_addr == hbm_pkg::ADDR_STATUS) begin
        stat_d = hbm_pkg::STAT_RST;
      end
    end
    if (reg_wr && reg_addr == hbm_pkg::ADDR_MASK) begin
      mask_d = reg_wdata[3:0];
    end
    // Set wins over read-clear so no event is lost
    stat_d = stat_d | live;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_q  <= hbm_pkg::STAT_RST;
      mask_q  <= hbm_pkg::MASK_RST;
      rdata_q <= 8'h00;
      alarm_q <= 1'b0;
    end else begin
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
      alarm_q <= |live;
    end
  end

  assign reg_rdata   = rdata_q;
  assign irq         = |(stat_q & mask_q);
  // Low supply alarms at once, without waiting on a register
  assign alarm_out_n = ~(alarm_q | low_supply_in);
endmodule : hbm_core
`default_nettype wire

// *** core/hbm_pkg.sv ***
// Package of constants for the H-bridge motor control and fault logic.
// Assumes a single 20 MHz system clock and a synchronous reset.
`default_nettype none
package hbm_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned PWM_HZ          = 44_500;
  localparam int unsigned PWM_PERIOD      = CLK_HZ / PWM_HZ;
  localparam int unsigned RAMP_MS         = 12;
  localparam int unsigned RAMP_TOTAL      = CLK_HZ / 1000 * RAMP_MS;
  localparam int unsigned RAMP_STEP_CYC   = RAMP_TOTAL / 256;
  localparam int unsigned ILIM_FILT_US    = 3;
  localparam int unsigned ILIM_FILT_CYC   = (CLK_HZ / 1_000_000) * ILIM_FILT_US;
  localparam int unsigned ILIM_FAULT_MS   = 275;
  localparam int unsigned ILIM_FAULT_CYC  = CLK_HZ / 1000 * ILIM_FAULT_MS;
  localparam int unsigned OCP_DEGLITCH_US = 2;
  localparam int unsigned OCP_DEGLITCH_CYC =
    (CLK_HZ / 1_000_000) * OCP_DEGLITCH_US;
  // ****************************************************************
  // Fixed widths and values
  // ****************************************************************
  localparam int unsigned DUTY_W      = 8;
  localparam logic [7:0]  DUTY_FULL   = 8'hFF;
  localparam logic [7:0]  DUTY_ZERO   = 8'h00;
  localparam int unsigned VDIV_SHIFT  = 2;
  localparam int unsigned ADC_W       = 10;
  localparam int unsigned CNT_W       = 24;
  localparam int unsigned STAT_W      = 4;
  localparam logic [3:0]  STAT_RST    = 4'h0;
  localparam logic [3:0]  MASK_RST    = 4'hF;
  // Status bit positions
  localparam int unsigned ST_ILIM = 0;
  localparam int unsigned ST_OCP  = 1;
  localparam int unsigned ST_OTS  = 2;
  localparam int unsigned ST_UV   = 3;
  // Register indices
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_MASK   = 2'h1;
  localparam logic [1:0] ADDR_LIVE   = 2'h2;
  localparam logic [1:0] ADDR_DUTY   = 2'h3;
  // Bridge modes
  typedef enum logic [1:0] {
    HBM_COAST   = 2'b00,
    HBM_REVERSE = 2'b01,
    HBM_FORWARD = 2'b10,
    HBM_BRAKE   = 2'b11
  } hbm_mode_t;
endpackage : hbm_pkg
`default_nettype wire

// *** core/hbm_pwm.sv ***
// PWM carrier: free-running period counter and on-time compare.
// Assumes a duty code where full scale means always on.
`default_nettype none
module hbm_pwm (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic [hbm_pkg::DUTY_W-1:0] duty,
  output logic                           on_time,
  output logic                           period_start
);
  // ****************************************************************
  // Carrier
  // ****************************************************************
  localparam logic [8:0] PER = 9'(hbm_pkg::PWM_PERIOD - 1);
  logic [8:0] ph_q;
  logic [8:0] ph_d;
  logic       on_q;
  logic       on_d;
  logic [16:0] scaled;

  // Scale duty to period; full code is forced to 100 percent by the compare below
  assign scaled = 17'(duty) * 17'(PER + 9'h001);

  always_comb begin
    ph_d = (ph_q == PER) ? 9'h000 : ph_q + 9'h001;
    if (duty == hbm_pkg::DUTY_FULL) begin
      on_d = 1'b1;
    end else begin
      on_d = ({8'h00, ph_d} < scaled[16:8]) ? 1'b1 : 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ph_q <= 9'h000;
      on_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      on_q <= on_d;
    end
  end

  assign on_time      = on_q;
  assign period_start = (ph_q == PER);
endmodule : hbm_pwm
`default_nettype wire

// *** core/hbm_timer.sv ***
// Persistence timer: counts while its condition holds, then holds expired high until it drops.
// Assumes the condition is synchronous to sys_clk.
`default_nettype none
module hbm_timer #(
  parameter int unsigned LIMIT = 40
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic cond,
  output logic      expired
);
  // ****************************************************************
  // Counter
  // ****************************************************************
  logic [hbm_pkg::CNT_W-1:0] cnt_q;
  logic [hbm_pkg::CNT_W-1:0] cnt_d;
  logic                      exp_q;
  logic                      exp_d;
  localparam logic [hbm_pkg::CNT_W-1:0] LIM = LIMIT[hbm_pkg::CNT_W-1:0];

  // Restart whenever the condition drops
  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (!cond) begin
      cnt_d = '0;
      exp_d = 1'b0;
    end else if (cnt_q < LIM) begin
      cnt_d = cnt_q + 1'b1;
    end else begin
      exp_d = 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;
endmodule : hbm_timer
`default_nettype wire

// *** dv/hbm_core_asserts.sv ***
// Concurrent checks on the ports of hbm_core, attached by bind.
// Assumes one sys_clk domain and a synchronous active-high rst.
`default_nettype none
module hbm_core_asserts (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       dir_ctrl_a,
  input wire logic       dir_ctrl_b,
  input wire logic [1:0] hs_overcurrent_in,
  input wire logic [1:0] ls_overcurrent_in,
  input wire logic       overtemp_in,
  input wire logic       low_supply_in,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] hs_gate,
  input wire logic [1:0] ls_gate,
  input wire logic       sleep_out,
  input wire logic       alarm_out_n
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic [5:0] oc_cnt_q;
  logic [5:0] oc_cnt_d;
  logic       oc_seen_q;
  logic       oc_seen_d;
  logic [1:0] dir;
  logic       gates_off;
  logic       quiet;
  assign dir       = {dir_ctrl_a, dir_ctrl_b};
  assign gates_off = (hs_gate == 2'h0) && (ls_gate == 2'h0);
  assign quiet     = !overtemp_in && !low_supply_in && alarm_out_n;
  // Overcurrent persistence; supply loss clears the latch like reset
  always_comb begin
    oc_cnt_d  = 6'h00;
    oc_seen_d = oc_seen_q && !low_supply_in;
    if ((|{hs_overcurrent_in, ls_overcurrent_in}) && !low_supply_in) begin
      oc_cnt_d = (oc_cnt_q == 6'h28) ? oc_cnt_q : oc_cnt_q + 6'h01;
      if (oc_cnt_q == 6'h27) oc_seen_d = 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oc_cnt_q  <= 6'h00;
      oc_seen_q <= 1'b0;
    end else begin
      oc_cnt_q  <= oc_cnt_d;
      oc_seen_q <= oc_seen_d;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_fwd_entry;
    dir == 2'b00 ##1 (dir == 2'b10 && quiet);
  endsequence
  sequence s_off_time;
    (hs_gate == 2'b11 && ls_gate == 2'b00) [*8];
  endsequence
  chk_coast_off: assert property (
    dir == 2'b00 |=> gates_off && sleep_out) else $error("Coast not off");
  chk_brake_gates: assert property (
    dir == 2'b11 && quiet |=> hs_gate == 2'b11 && ls_gate == 2'b00
    && !sleep_out) else $error("Brake gates wrong");
  chk_gate_pairs: assert property (
    ls_gate != 2'b00 |-> hs_gate == ~ls_gate && ls_gate != 2'b11)
    else $error("Shoot-through gate pattern");
  chk_drive_side: assert property (
    dir[1] ^ dir[0] |=> ls_gate == 2'b00 || ls_gate == $past(dir))
    else $error("Low side of wrong leg on");
  chk_soft_start: assert property (
    s_fwd_entry |=> s_off_time) else $error("Drive began above zero duty");
  chk_ocp_trip: assert property (
    $rose(oc_seen_q) |-> ##[0:3] (gates_off && !alarm_out_n))
    else $error("Overcurrent did not shut down");
  chk_ocp_hold: assert property (
    oc_seen_q && $past(oc_seen_q, 3) |-> gates_off && !alarm_out_n)
    else $error("Overcurrent shutdown released");
  chk_temp_off: assert property (
    overtemp_in [*2] |-> gates_off && !alarm_out_n)
    else $error("Overtemperature not handled");
  chk_uv_alarm: assert property (
    low_supply_in [*2] |-> gates_off && !alarm_out_n)
    else $error("Low supply not handled");
  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("Read data not idle");
endmodule : hbm_core_asserts
bind hbm_core hbm_core_asserts u_chk (.sys_clk, .rst, .dir_ctrl_a,
  .dir_ctrl_b, .hs_overcurrent_in, .ls_overcurrent_in, .overtemp_in,
  .low_supply_in, .reg_rd, .reg_rdata, .hs_gate, .ls_gate, .sleep_out,
  .alarm_out_n);
`default_nettype wire

// *** dv/hbm_host_model.sv ***
// Host model: sets the direction inputs and watches the alarm line.
// Assumes the bench asks for modes and reset is synchronous.
`default_nettype none
module hbm_host_model #(
  parameter int unsigned HOLD_CYC = 16
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [1:0] mode_req,
  input  wire logic       alarm_out_n,
  output logic            dir_ctrl_a,
  output logic            dir_ctrl_b,
  output logic            alarm_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Direction control
  // ****************************************
  logic [4:0] hold_q;
  logic [4:0] hold_d;
  logic [1:0] dir_q;
  logic [1:0] dir_d;
  // Changes are spaced out; fast toggling would restart soft start
  always_comb begin
    dir_d  = dir_q;
    hold_d = (hold_q != 5'h00) ? hold_q - 5'h01 : hold_q;
    if (hold_q == 5'h00 && mode_req != dir_q) begin
      dir_d  = mode_req;
      hold_d = 5'(HOLD_CYC);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dir_q      <= 2'b00;
      hold_q     <= 5'h00;
      alarm_seen <= 1'b0;
    end else begin
      dir_q      <= dir_d;
      hold_q     <= hold_d;
      alarm_seen <= !alarm_out_n;
    end
  end
  assign {dir_ctrl_a, dir_ctrl_b} = dir_q;
endmodule : hbm_host_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for hbm_core with the host model on its pins.
// Assumes the package and design files are compiled first.
`default_nettype none
`define CHK(g, e) chk(16'(g), 16'(e))
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic       sys_clk;
  logic       rst;
  logic [1:0] mode_req;
  logic       dir_ctrl_a;
  logic       dir_ctrl_b;
  logic       alarm_seen;
  logic [9:0] speed_setpoint_in;
  logic [9:0] out_diff_in;
  logic [9:0] supply_in;
  logic       sense_resistor_in;
  logic [1:0] hs_overcurrent_in;
  logic [1:0] ls_overcurrent_in;
  logic       overtemp_in;
  logic       low_supply_in;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       irq;
  logic [1:0] hs_gate;
  logic [1:0] ls_gate;
  logic       sleep_out;
  logic       alarm_out_n;
  logic [7:0] d0;
  logic [7:0] d1;
  int         num_errors;
  int         n_compared;
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  hbm_host_model host (.sys_clk, .rst, .mode_req, .alarm_out_n,
    .dir_ctrl_a, .dir_ctrl_b, .alarm_seen);
  hbm_core dut (.sys_clk, .rst, .dir_ctrl_a, .dir_ctrl_b,
    .speed_setpoint_in, .out_diff_in, .supply_in, .sense_resistor_in,
    .hs_overcurrent_in, .ls_overcurrent_in, .overtemp_in, .low_supply_in,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .hs_gate,
    .ls_gate, .sleep_out, .alarm_out_n);
  // ****************************************
  // Tasks
  // ****************************************
  // Wide enough that flag bits beside a data byte are not cut off
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd
  // Host needs its hold time before the next mode change
  task automatic mode(input logic [1:0] m);
    @(posedge sys_clk);
    mode_req <= m;
    cyc(24);
    @(negedge sys_clk);
  endtask : mode
  task automatic oc_pulse(input int side, input int n);
    @(posedge sys_clk);
    hs_overcurrent_in <= (side == 0) ? 2'b01 : 2'b00;
    ls_overcurrent_in <= (side == 1) ? 2'b10 : 2'b00;
    cyc(n);
    hs_overcurrent_in <= 2'b00;
    ls_overcurrent_in <= 2'b00;
    cyc(4);
    @(negedge sys_clk);
  endtask : oc_pulse
  task automatic results;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // Watchdog sized well above the whole sequence
  initial begin
    cyc(80000);
    num_errors++;
    results();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {rst, mode_req, reg_addr, reg_wdata, reg_wr, reg_rd} = 15'h4000;
    {speed_setpoint_in, out_diff_in, supply_in} = {10'h0F0, 10'h000, 10'h3FF};
    {sense_resistor_in, hs_overcurrent_in, ls_overcurrent_in} = 5'h00;
    {overtemp_in, low_supply_in, num_errors, n_compared} = '0;
    cyc(3);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK({sleep_out, alarm_out_n, hs_gate, ls_gate}, 6'h30);
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), d0);
      `CHK(d0, (i == 1) ? 8'h0F : 8'h00);
    end
    wr(hbm_pkg::ADDR_LIVE, 8'hFF);
    rd(hbm_pkg::ADDR_LIVE, d0);
    `CHK(d0, 8'h00);
    mode(hbm_pkg::HBM_BRAKE);
    `CHK({sleep_out, hs_gate, ls_gate}, 5'h0C);
    mode(hbm_pkg::HBM_COAST);
    `CHK({sleep_out, hs_gate, ls_gate}, 5'h10);
    for (int i = 0; i < 2; i++) begin
      mode(i ? hbm_pkg::HBM_REVERSE : hbm_pkg::HBM_FORWARD);
      `CHK({hs_gate, ls_gate}, 4'hC);
      rd(hbm_pkg::ADDR_DUTY, d0);
      `CHK(d0, 8'h00);
      cyc(3000);
      rd(hbm_pkg::ADDR_DUTY, d0);
      `CHK(d0 inside {[8'h01:8'h04]}, 1'b1);
      for (int k = 0; k < 500 && ls_gate === 2'b00; k++) @(negedge sys_clk);
      `CHK({hs_gate, ls_gate}, i ? 4'h9 : 4'h6);
      out_diff_in <= 10'h3FF;
      rd(hbm_pkg::ADDR_DUTY, d0);
      cyc(2000);
      rd(hbm_pkg::ADDR_DUTY, d1);
      `CHK(d1 < d0, 1'b1);
      out_diff_in <= 10'h000;
      cyc(3000);
      rd(hbm_pkg::ADDR_DUTY, d0);
      sense_resistor_in <= 1'b1;
      cyc(2000);
      rd(hbm_pkg::ADDR_DUTY, d1);
      `CHK(d1 < d0, 1'b1);
      sense_resistor_in <= 1'b0;
      mode(hbm_pkg::HBM_COAST);
    end
    for (int i = 0; i < 2; i++) begin
      mode(hbm_pkg::HBM_FORWARD);
      oc_pulse(i, 20);
      `CHK(alarm_out_n, 1'b1);
      oc_pulse(i, 50);
      `CHK({irq, alarm_out_n, hs_gate, ls_gate}, 6'h20);
      rd(hbm_pkg::ADDR_STATUS, d0);
      `CHK(d0, 8'h02);
      wr(hbm_pkg::ADDR_MASK, 8'h00);
      cyc(2);
      @(negedge sys_clk);
      `CHK(irq, 1'b0);
      mode(hbm_pkg::HBM_BRAKE);
      `CHK({hs_gate, ls_gate}, 4'h0);
      rst <= 1'b1;
      cyc(1);
      rst <= 1'b0;
      mode(hbm_pkg::HBM_COAST);
    end
    mode(hbm_pkg::HBM_FORWARD);
    overtemp_in <= 1'b1;
    cyc(4);
    @(negedge sys_clk);
    `CHK({alarm_seen, alarm_out_n, hs_gate, ls_gate}, 6'h20);
    rd(hbm_pkg::ADDR_LIVE, d0);
    `CHK(d0, 8'h04);
    overtemp_in <= 1'b0;
    cyc(4);
    @(negedge sys_clk);
    `CHK({irq, alarm_out_n, hs_gate != 2'b00}, 3'h7);
    rd(hbm_pkg::ADDR_STATUS, d0);
    `CHK(d0, 8'h04);
    rd(hbm_pkg::ADDR_STATUS, d0);
    `CHK({irq, d0}, 9'h000);
    @(posedge sys_clk);
    low_supply_in <= 1'b1;
    #1;
    `CHK(alarm_out_n, 1'b0);
    cyc(4);
    low_supply_in <= 1'b0;
    cyc(4);
    rd(hbm_pkg::ADDR_DUTY, d0);
    `CHK({alarm_out_n, d0}, 9'h100);
    rd(hbm_pkg::ADDR_STATUS, d0);
    `CHK(d0, 8'h08);
    // High output would pull duty to zero unless the bypass takes over
    out_diff_in <= 10'h3FF;
    supply_in   <= 10'h100;
    cyc(3500);
    rd(hbm_pkg::ADDR_DUTY, d0);
    `CHK(d0, 8'h03);
    results();
  end
endmodule : tb_top
`default_nettype wire
